// *** bench/sdram_host_model.sv ***
// Purpose: memory controller model driving link clock, enable, strobes and address
// Assumes: link clock 125 ns, stopped low while not running
// Notes: one command per link edge, NOP in between, all changes by NBA after an edge
`timescale 1ns/10ps
`default_nettype none
module sdram_host_model (
    // Link pins toward the device
    output logic sd_clk_o,
    output logic cke_o,
    output sdram_cmd_pkg::sd_cmd_t cmd_o,
    output logic [sdram_cmd_pkg::ADDR_W-1:0] addr_o,
    output logic [1:0] ba_o,
    output logic [sdram_cmd_pkg::LANES-1:0] dqm_o
);
    logic run;
    // Idle pin levels at time zero
    initial begin
        run = 1'b0;
        sd_clk_o = 1'b0;
        cke_o = 1'b1;
        cmd_o = 4'h7;
        addr_o = 12'h000;
        dqm_o = 2'h0;
    end
    // Link clock, held low while stopped
    always begin
        #62.5;
        sd_clk_o = run ? ~sd_clk_o : 1'b0;
    end
    // Start or stop the link clock
    task automatic set_run(input logic r);
        run = r;
    endtask : set_run
    // Byte mask change just after an edge
    task automatic set_dqm(input logic [1:0] d);
        @(posedge sd_clk_o);
        dqm_o <= d;
    endtask : set_dqm
    // One command for one edge, then NOP with a changed address
    task automatic send(input logic [3:0] c, input logic [11:0] a, input logic [1:0] b, input logic k);
        @(posedge sd_clk_o);
        cmd_o <= c;
        addr_o <= a;
        ba_o <= b;
        cke_o <= k;
        @(posedge sd_clk_o);
        cmd_o <= 4'h7;
        addr_o <= ~a;
        ba_o <= 2'h0;
    endtask : send
endmodule : sdram_host_model
`default_nettype wire

// *** bench/sdram_mode_and_command_logic_bench.sv ***
// Purpose: self-checking bench for the SDRAM command and mode block
// Assumes: host model drives the link, bench owns the internal clock and reset
// Notes: expectations built from burst order and mode field layout
`timescale 1ns/10ps
`default_nettype none
module sdram_mode_and_command_logic_bench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sd_clk, cke, drive_weak, mode_valid, self_ref, refresh, beat_vld;
    sdram_cmd_pkg::sd_cmd_t cmd;
    sdram_cmd_pkg::mode_t op_mode;
    logic [11:0] addr, row, refresh_row, cur_mode, d;
    logic [1:0] ba, dqm, wr_store, dq_oe_b;
    logic [7:0] col;
    int num_errors = 0;
    int n_compared = 0;
    int cl = 2;
    int n_refresh = 0;
    int ref_mark;
    sdram_host_model u_host (.sd_clk_o(sd_clk), .cke_o(cke), .cmd_o(cmd), .addr_o(addr), .ba_o(ba), .dqm_o(dqm));
    sdram_cmd_core u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sd_clk_i(sd_clk), .cke_i(cke), .cmd_i(cmd),
        .addr_i(addr), .ba_i(ba), .dqm_i(dqm), .col_o(col), .beat_vld_o(beat_vld), .wr_store_o(wr_store),
        .dq_oe_b_o(dq_oe_b), .drive_weak_o(drive_weak), .op_mode_o(op_mode), .mode_valid_o(mode_valid),
        .self_ref_o(self_ref), .refresh_o(refresh), .refresh_row_o(refresh_row));
    // Internal clock, 4 ns
    always #2 clk_i = ~clk_i;
    // Refresh pulses counted away from the launching edge
    always @(negedge clk_i) begin
        if (refresh === 1'b1) n_refresh++;
    end
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // Counts and verdict
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // Mode load with reserved bits low, then read back the crossed copy
    task automatic load_mode(input logic [2:0] bl, input logic bt, input logic [2:0] lat, input logic wbm);
        cur_mode = {2'h0, wbm, 2'h0, lat, bt, bl};
        u_host.send({1'b0, sdram_cmd_pkg::ENC_MODE}, cur_mode, 2'h0, 1'b1);
        repeat (3) @(posedge sd_clk);
        check(op_mode, cur_mode);
        check(mode_valid, 1'b1);
    endtask : load_mode
    // Burst command, then beat-by-beat column order
    task automatic run_burst(input logic [2:0] enc, input logic [7:0] st, input int n, input logic il,
                             input int beats);
        logic [7:0] msk;
        logic [7:0] want;
        msk = 8'(n - 1);
        u_host.send({1'b0, enc}, {4'h0, st}, 2'h0, 1'b1);
        for (int i = 0; i < beats; i++) begin
            #1;
            want = il ? (st ^ 8'(i)) : ((st & ~msk) | ((st + 8'(i)) & msk));
            check(col, want);
            check(beat_vld, 1'b1);
            if (enc == sdram_cmd_pkg::ENC_WRITE) check(wr_store, 2'(~dqm));
            if (enc == sdram_cmd_pkg::ENC_READ && i == cl - 1) check(dq_oe_b, dqm);
            if (i < beats - 1) @(posedge sd_clk);
        end
    endtask : run_burst
    // Burst over on the following cycle
    task automatic idle_after();
        @(posedge sd_clk);
        #1;
        check(beat_vld, 1'b0);
        check(wr_store, 2'h0);
    endtask : idle_after
    // Hang guard
    initial begin
        #200_000;
        num_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        check(op_mode, sdram_cmd_pkg::MODE_RESET);
        check(dq_oe_b, 2'h3);
        rst_b_i <= 1'b1;
        u_host.set_run(1'b1);
        @(posedge sd_clk);
        load_mode(sdram_cmd_pkg::BL_4, 1'b0, sdram_cmd_pkg::CL_2, 1'b0);
        cl = 2;
        u_host.set_dqm(2'h1);
        run_burst(sdram_cmd_pkg::ENC_WRITE, 8'h05, 4, 1'b0, 4);
        idle_after();
        u_host.set_dqm(2'h2);
        run_burst(sdram_cmd_pkg::ENC_READ, 8'h0e, 4, 1'b0, 4);
        idle_after();
        load_mode(sdram_cmd_pkg::BL_8, 1'b1, sdram_cmd_pkg::CL_3, 1'b0);
        cl = 3;
        run_burst(sdram_cmd_pkg::ENC_READ, 8'h05, 8, 1'b1, 8);
        idle_after();
        load_mode(sdram_cmd_pkg::BL_FULL, 1'b1, sdram_cmd_pkg::CL_2, 1'b0);
        cl = 2;
        run_burst(sdram_cmd_pkg::ENC_READ, 8'hfe, 256, 1'b0, 4);
        u_host.send({1'b0, sdram_cmd_pkg::ENC_STOP}, 12'h000, 2'h0, 1'b1);
        #1;
        check(beat_vld, 1'b0);
        load_mode(sdram_cmd_pkg::BL_4, 1'b0, sdram_cmd_pkg::CL_2, 1'b1);
        u_host.set_dqm(2'h0);
        run_burst(sdram_cmd_pkg::ENC_WRITE, 8'h02, 4, 1'b0, 1);
        idle_after();
        // Deselected mode load and a NOP leave the mode alone
        u_host.send({1'b1, sdram_cmd_pkg::ENC_MODE}, 12'h033, 2'h0, 1'b1);
        u_host.send(4'h7, 12'h033, 2'h0, 1'b1);
        repeat (3) @(posedge sd_clk);
        check(op_mode, cur_mode);
        u_host.send({1'b0, sdram_cmd_pkg::ENC_MODE}, 12'h002, 2'h2, 1'b1);
        repeat (3) @(posedge sd_clk);
        check(drive_weak, 1'b1);
        check(op_mode, cur_mode);
        // Auto refresh steps the row by one
        row = refresh_row;
        ref_mark = n_refresh;
        u_host.send({1'b0, sdram_cmd_pkg::ENC_REF}, 12'hfff, 2'h0, 1'b1);
        repeat (2) @(posedge sd_clk);
        check(refresh_row, row + 12'h001);
        check(16'(n_refresh - ref_mark), 16'h0001);
        // Self refresh with the link clock stopped
        u_host.send({1'b0, sdram_cmd_pkg::ENC_REF}, 12'h000, 2'h0, 1'b0);
        repeat (2) @(posedge sd_clk);
        u_host.set_run(1'b0);
        #1;
        check(self_ref, 1'b1);
        row = refresh_row;
        #39_060;
        d = refresh_row - row;
        check(d >= 12'h002 && d <= 12'h003, 1'b1);
        u_host.set_run(1'b1);
        u_host.send(4'h7, 12'h000, 2'h0, 1'b1);
        repeat (4) @(posedge sd_clk);
        check(self_ref, 1'b0);
        load_mode(sdram_cmd_pkg::BL_2, 1'b0, sdram_cmd_pkg::CL_3, 1'b0);
        cl = 3;
        run_burst(sdram_cmd_pkg::ENC_READ, 8'h01, 2, 1'b0, 2);
        idle_after();
        // Enable low mid-burst holds the beat, high resumes it
        load_mode(sdram_cmd_pkg::BL_8, 1'b0, sdram_cmd_pkg::CL_2, 1'b0);
        u_host.send({1'b0, sdram_cmd_pkg::ENC_WRITE}, 12'h00c, 2'h0, 1'b1);
        u_host.send(4'h7, 12'h000, 2'h0, 1'b0);
        @(posedge sd_clk);
        #1;
        check(col, 8'h0e);
        check(beat_vld, 1'b1);
        u_host.send(4'h7, 12'h000, 2'h0, 1'b1);
        #1;
        check(col, 8'h0e);
        @(posedge sd_clk);
        #1;
        check(col, 8'h0f);
        repeat (4) @(posedge sd_clk);
        #1;
        check(col, 8'h0b);
        idle_after();
        // Power-down ignores a mode load
        u_host.send(4'h7, 12'h000, 2'h0, 1'b0);
        u_host.send({1'b0, sdram_cmd_pkg::ENC_MODE}, 12'h023, 2'h0, 1'b0);
        repeat (3) @(posedge sd_clk);
        check(op_mode, cur_mode);
        u_host.send(4'h7, 12'h000, 2'h0, 1'b1);
        load_mode(sdram_cmd_pkg::BL_4, 1'b0, sdram_cmd_pkg::CL_2, 1'b0);
        wrap_up();
    end
endmodule : sdram_mode_and_command_logic_bench
`default_nettype wire

// *** core/sdram_cmd_core.sv ***
// Purpose: SDRAM command decode, mode registers, burst order, power states
// Assumes: pins sampled on sd_clk_i; clk_i is the internal refresh clock
// Notes: row counter lives on clk_i so self refresh runs with sd_clk_i stopped
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE1] Mode load latches A0-A9, A11 promptly
// [RULE2] Reprogram only with all banks idle
// [RULE3] Mode undefined until first mode load
// [RULE4] Reserved bits, A10, bank lines low; here a mode load with ba_i bit 1 high loads ext_mode instead of mode
// [RULE5] A2-A0 select burst length
// [RULE6] A3 selects sequential or interleaved order
// [RULE7] Sequential bursts wrap in aligned block
// [RULE8] Interleaved column is start XOR beat
// [RULE9] Full page wraps 255 to 0, sequential
// [RULE10] A6-A4 set read latency 2 or 3
// [RULE11] Controller picks smallest sufficient latency
// [RULE12] A9 makes writes single beat
// [RULE13] Deselect ignores inputs; all-high strobes is NOP
// [RULE14] Burst stop ends burst, read drains latency
// [RULE15] Auto refresh steps internal row counter
// [RULE16] Refresh needs idle banks and spacing
// [RULE17] Refresh with enable low enters self refresh
// [RULE18] Self refresh exit needs NOP spacing
// [RULE19] Burst refreshes around self refresh
// [RULE20] Enable low freezes burst or powers down
// [RULE21] Enable high resumes next cycle
// [RULE22] Byte mask blocks writes, disables read drivers
// [RULE23] Never load reserved length or latency
module sdram_cmd_core (
    // Internal clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link pins
    input wire logic sd_clk_i,
    input wire logic cke_i,
    input wire sdram_cmd_pkg::sd_cmd_t cmd_i,
    input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [1:0] ba_i,
    input wire logic [sdram_cmd_pkg::LANES-1:0] dqm_i,
    // Burst datapath controls, link domain
    output logic [sdram_cmd_pkg::COL_W-1:0] col_o,
    output logic beat_vld_o,
    output logic [sdram_cmd_pkg::LANES-1:0] wr_store_o,
    output logic [sdram_cmd_pkg::LANES-1:0] dq_oe_b_o,
    output logic drive_weak_o,
    // Internal domain status
    output sdram_cmd_pkg::mode_t op_mode_o,
    output logic mode_valid_o,
    output logic self_ref_o,
    output logic refresh_o,
    output logic [sdram_cmd_pkg::ROW_W-1:0] refresh_row_o
);
    sdram_cmd_pkg::link_state_t state;
    sdram_cmd_pkg::link_state_t next_state;
    sdram_cmd_pkg::mode_t mode;
    logic [11:0] ext_mode;
    logic cke_q;
    logic [sdram_cmd_pkg::COL_W-1:0] start_col;
    logic [sdram_cmd_pkg::BEAT_W-1:0] beat;
    logic burst_wr;
    logic beat_rd;
    logic [1:0] rd_pipe;
    logic [sdram_cmd_pkg::LANES-1:0] dqm_d1;
    logic [sdram_cmd_pkg::LANES-1:0] dqm_d2;
    logic mode_tgl;
    logic aref_tgl;

    // Command decode on the link clock
    wire [2:0] enc = {cmd_i.ras_b, cmd_i.cas_b, cmd_i.we_b};
    wire awake = (state == sdram_cmd_pkg::LINK_IDLE) || (state == sdram_cmd_pkg::LINK_BURST);
    wire cmd_ok = cke_q && !cmd_i.cs_b && awake; // RULE13
    wire mode_go = cmd_ok && cke_i && (enc == sdram_cmd_pkg::ENC_MODE);
    wire ref_go = cmd_ok && (enc == sdram_cmd_pkg::ENC_REF);
    wire aref_go = ref_go && cke_i;
    wire sref_go = ref_go && !cke_i;
    wire rd_go = cmd_ok && (enc == sdram_cmd_pkg::ENC_READ);
    wire wr_go = cmd_ok && (enc == sdram_cmd_pkg::ENC_WRITE);
    wire stop_go = cmd_ok && (enc == sdram_cmd_pkg::ENC_STOP);
    wire ext_sel = ba_i[sdram_cmd_pkg::EXT_SEL_BIT];
    wire frozen = !cke_q && (state == sdram_cmd_pkg::LINK_BURST); // RULE20

    // Burst length mask; writes single beat when A9 set
    wire single = burst_wr && mode.wbm; // RULE12
    wire full = (mode.bl == sdram_cmd_pkg::BL_FULL) && !single;
    wire [7:0] bl_mask = single ? 8'h00 :
        (mode.bl == sdram_cmd_pkg::BL_2) ? 8'h01 :
        (mode.bl == sdram_cmd_pkg::BL_4) ? 8'h03 :
        (mode.bl == sdram_cmd_pkg::BL_8) ? 8'h07 :
        full ? 8'hFF : 8'h00; // RULE5
    wire [7:0] beat_lo = beat[7:0];
    wire [7:0] seq_col = (start_col & ~bl_mask) | ((start_col + beat_lo) & bl_mask); // RULE7 RULE9
    wire [7:0] ilv_col = (start_col & ~bl_mask) | ((start_col ^ beat_lo) & bl_mask); // RULE8
    wire use_ilv = mode.bt && !full; // RULE6 RULE9
    wire [7:0] cur_col = use_ilv ? ilv_col : seq_col;
    wire beat_left = full || (beat_lo <= bl_mask); // Beat index still inside the burst
    wire last_beat = !full && (beat_lo >= bl_mask); // Final beat now, or none left at length 1

    // Power and burst state selection
    always_comb begin
        next_state = state;
        unique case (state)
            sdram_cmd_pkg::LINK_IDLE: begin
                if (sref_go) begin
                    next_state = sdram_cmd_pkg::LINK_SELFREF; // RULE17
                end else if (rd_go || wr_go) begin
                    next_state = sdram_cmd_pkg::LINK_BURST;
                end else if (!cke_i) begin
                    next_state = sdram_cmd_pkg::LINK_PDOWN; // RULE20
                end
            end
            sdram_cmd_pkg::LINK_BURST: begin
                if (!frozen && !rd_go && !wr_go && (stop_go || last_beat)) begin
                    next_state = sdram_cmd_pkg::LINK_IDLE; // RULE14
                end
            end
            sdram_cmd_pkg::LINK_PDOWN: begin
                if (cke_i) begin
                    next_state = sdram_cmd_pkg::LINK_IDLE; // RULE21
                end
            end
            sdram_cmd_pkg::LINK_SELFREF: begin
                if (cke_i) begin
                    next_state = sdram_cmd_pkg::LINK_IDLE;
                end
            end
        endcase
    end

    // Enable history and state
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cke_q <= 1'b0;
            state <= sdram_cmd_pkg::LINK_IDLE;
        end else begin
            cke_q <= cke_i;
            state <= next_state;
        end
    end

    // Mode registers and refresh event toggle
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= sdram_cmd_pkg::MODE_RESET;
            ext_mode <= sdram_cmd_pkg::MODE_RESET;
            mode_tgl <= 1'b0;
            aref_tgl <= 1'b0;
        end else begin
            if (mode_go && !ext_sel) begin
                mode <= addr_i & ~sdram_cmd_pkg::MODE_A10_MASK; // RULE1
                mode_tgl <= !mode_tgl;
            end
            if (mode_go && ext_sel) begin
                ext_mode <= addr_i & ~sdram_cmd_pkg::MODE_A10_MASK;
            end
            if (aref_go) begin
                aref_tgl <= !aref_tgl; // RULE15
            end
        end
    end

    // Burst beat engine, held while suspended
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_col <= 8'h00;
            beat <= 9'h000;
            burst_wr <= 1'b0;
        end else if (rd_go || wr_go) begin
            start_col <= addr_i[7:0];
            beat <= 9'h001;
            burst_wr <= wr_go;
        end else if (state == sdram_cmd_pkg::LINK_BURST && !frozen) begin
            beat <= beat + 9'h001;
        end
    end

    // Column output and write strobes
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            col_o <= 8'h00;
            beat_vld_o <= 1'b0;
            beat_rd <= 1'b0;
            wr_store_o <= 2'h0;
        end else if (!frozen) begin
            if (rd_go || wr_go) begin
                col_o <= addr_i[7:0];
                beat_vld_o <= 1'b1;
                beat_rd <= rd_go;
                wr_store_o <= wr_go ? ~dqm_i : 2'h0; // RULE22
            end else if (state == sdram_cmd_pkg::LINK_BURST && !stop_go && beat_left) begin
                col_o <= cur_col;
                beat_vld_o <= 1'b1;
                wr_store_o <= burst_wr ? ~dqm_i : 2'h0; // RULE22
            end else begin
                beat_vld_o <= 1'b0;
                beat_rd <= 1'b0;
                wr_store_o <= 2'h0;
            end
        end
    end

    // Read latency and two-cycle mask pipeline
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_pipe <= 2'h0;
            dqm_d1 <= 2'h3;
            dqm_d2 <= 2'h3;
        end else if (!frozen) begin
            rd_pipe <= {rd_pipe[0], beat_rd && beat_vld_o};
            dqm_d1 <= dqm_i;
            dqm_d2 <= dqm_d1;
        end
    end

    // Read drivers enabled low at the latency tap
    wire rd_tap = (mode.cl == sdram_cmd_pkg::CL_3) ? rd_pipe[1] : rd_pipe[0]; // RULE10
    assign dq_oe_b_o = ~({sdram_cmd_pkg::LANES{rd_tap}} & ~dqm_d2); // RULE22 RULE14
    assign drive_weak_o = ext_mode[sdram_cmd_pkg::EXT_DRIVE_BIT];

    // Crossings into clk_i: three stages, change once last two agree
    logic [2:0] mode_s;
    logic [2:0] aref_s;
    logic [2:0] sref_s;
    wire sref_lvl_src = (state == sdram_cmd_pkg::LINK_SELFREF);
    logic sref_lvl;
    always_ff @(posedge sd_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sref_lvl <= 1'b0;
        end else begin
            sref_lvl <= sref_lvl_src;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_s <= 3'h0;
            aref_s <= 3'h0;
            sref_s <= 3'h0;
        end else begin
            mode_s <= {mode_s[1:0], mode_tgl};
            aref_s <= {aref_s[1:0], aref_tgl};
            sref_s <= {sref_s[1:0], sref_lvl};
        end
    end

    logic mode_seen;
    logic aref_seen;
    wire mode_ev = (mode_s[1] == mode_s[2]) && (mode_s[2] != mode_seen);
    wire aref_ev = (aref_s[1] == aref_s[2]) && (aref_s[2] != aref_seen);
    logic [sdram_cmd_pkg::ROW_W-1:0] sr_timer;
    wire in_sref = (sref_s[1] == sref_s[2]) ? sref_s[2] : self_ref_o;
    wire sr_fire = in_sref && (sr_timer == sdram_cmd_pkg::SELF_REF_LAST); // RULE17

    // Internal domain: mode copy, refresh row counter, self refresh timer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_seen <= 1'b0;
            aref_seen <= 1'b0;
            op_mode_o <= sdram_cmd_pkg::MODE_RESET;
            mode_valid_o <= 1'b0;
            self_ref_o <= 1'b0;
            sr_timer <= 12'h000;
            refresh_o <= 1'b0;
            refresh_row_o <= 12'h000;
        end else begin
            mode_seen <= mode_s[2];
            aref_seen <= aref_s[2];
            self_ref_o <= in_sref;
            if (mode_ev) begin
                op_mode_o <= mode; // stable: no reload within two link cycles
                mode_valid_o <= 1'b1; // RULE3
            end
            sr_timer <= (!in_sref || sr_fire) ? 12'h000 : sr_timer + 12'h001;
            refresh_o <= aref_ev || sr_fire;
            if (aref_ev || sr_fire) begin
                refresh_row_o <= refresh_row_o + 12'h001; // RULE15
            end
        end
    end

    // Link domain checks
    sequence s_read_cl2;
        rd_go && mode.cl == sdram_cmd_pkg::CL_2 && cke_i;
    endsequence
    sequence s_then_run;
        ##1 cke_i;
    endsequence

    a_mode_latch: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE1
        mode_go && !ext_sel |=> mode == ($past(addr_i) & ~sdram_cmd_pkg::MODE_A10_MASK))
        else $error("mode word not latched");
    a_seq_wrap: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE7
        beat_vld_o && !use_ilv && state == sdram_cmd_pkg::LINK_BURST && !frozen && !stop_go
        && beat_left && !rd_go && !wr_go |=> ((col_o & $past(bl_mask)) ==
        (($past(col_o) + 8'h01) & $past(bl_mask))))
        else $error("sequential column step wrong");
    a_ilv_order: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE8
        beat_vld_o && use_ilv && state == sdram_cmd_pkg::LINK_BURST && !frozen && !stop_go
        && beat_left && !rd_go && !wr_go |=> col_o == (start_col ^ (8'($past(beat)) & bl_mask)))
        else $error("interleaved column wrong");
    a_page_wrap: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE9
        beat_vld_o && full && col_o == 8'hFF && !frozen && !stop_go && !rd_go && !wr_go
        |=> col_o == 8'h00 && beat_vld_o)
        else $error("full page did not wrap to zero");
    a_single_write: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE12
        wr_go && mode.wbm ##1 !rd_go && !wr_go && cke_q |=> !beat_vld_o)
        else $error("single write ran past one beat");
    a_deselect_hold: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE13
        cmd_i.cs_b |=> $stable(mode) && $stable(ext_mode) && $stable(aref_tgl))
        else $error("deselected command took effect");
    a_stop_ends: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE14
        stop_go && !frozen |=> !beat_vld_o)
        else $error("burst stop ignored");
    a_read_latency: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE10
        s_read_cl2 ##0 s_then_run |=> dq_oe_b_o == $past(dqm_i, 2))
        else $error("read data not driven at latency two");
    a_sref_hold: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE17
        sref_go |=> state == sdram_cmd_pkg::LINK_SELFREF ##0 (!beat_vld_o)[*1])
        else $error("self refresh not entered");
    a_suspend_freeze: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE20
        frozen |=> $stable(col_o) && $stable(beat) && $stable(rd_pipe))
        else $error("suspended burst moved");
    a_pd_exit: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE21
        state == sdram_cmd_pkg::LINK_PDOWN && cke_i |=> state == sdram_cmd_pkg::LINK_IDLE)
        else $error("power-down exit late");
    a_read_mask: assert property (@(posedge sd_clk_i) disable iff (!rst_b_i) // RULE22
        !frozen && !$past(frozen) && dq_oe_b_o != 2'h3 |-> (dq_oe_b_o | ~$past(dqm_i, 2)) == 2'h3)
        else $error("masked byte driven on read");

    // Internal domain check
    a_row_step: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
        aref_ev |=> refresh_row_o == $past(refresh_row_o) + 12'h001 && refresh_o)
        else $error("refresh row did not step");
endmodule : sdram_cmd_core
`default_nettype wire

// *** core/sdram_cmd_pkg.sv ***
// Purpose: shared constants and types for the SDRAM command block
// Assumes: 12 address pins, 8-bit column, 2 byte lanes
// Notes: mode word keeps A10 position at zero
package sdram_cmd_pkg;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BEAT_W = 9;
    localparam int ROW_W = 12;
    localparam int LANES = 2;
    // Strobe encodings {row, column, write}
    localparam logic [2:0] ENC_MODE = 3'h0;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_WRITE = 3'h4;
    localparam logic [2:0] ENC_READ = 3'h5;
    localparam logic [2:0] ENC_STOP = 3'h6;
    // Burst length and read latency codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [11:0] MODE_A10_MASK = 12'h0400;
    localparam logic [11:0] MODE_RESET = 12'h0000;
    localparam int EXT_DRIVE_BIT = 1;
    localparam int EXT_SEL_BIT = 1;
    // Self refresh spacing: refresh window over row count
    localparam longint REF_WINDOW_NS = 64_000_000;
    localparam int REF_ROWS = 4096;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SELF_REF_CYCLES = int'(REF_WINDOW_NS / REF_ROWS / CLK_PERIOD_NS);
    localparam logic [ROW_W-1:0] SELF_REF_LAST = ROW_W'(SELF_REF_CYCLES - 1);
    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
    } sd_cmd_t;
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic wbm;
        logic [1:0] rsv;
        logic [2:0] cl;
        logic bt;
        logic [2:0] bl;
    } mode_t;
    typedef enum logic [1:0] {LINK_IDLE, LINK_BURST, LINK_PDOWN, LINK_SELFREF} link_state_t;
endpackage : sdram_cmd_pkg
